// *** verilog/sfra_top.v ***
// Packed-integer register file aliased onto the floating-point data registers,
// with the tag word, status word and control flags behind an AXI4-Lite slave.
// Assumes execution logic and the floating-point unit share aclk.
//
// Summary of operation
// RULE_01 - Emulation set gives invalid-opcode, else task-switched gives not-available, else run.
// RULE_02 - A set emulation flag never emulates packed instructions, it always faults.
// RULE_03 - Software should keep the monitor-coprocessor flag set.
// RULE_04 - Eight 64-bit packed registers are the low 64 bits of the eight data registers.
// RULE_05 - Packed register n is physical data register n, regardless of top of stack.
// RULE_06 - Writes on either view are seen in the low 64 bits of the other.
// RULE_07 - A packed register write sets bits 64 to 79 of that data register to ones.
// RULE_08 - Every packed instruction except state clear marks all tags valid.
// RULE_09 - The state-clear instruction marks all tags empty.
// RULE_10 - Every packed instruction loads zero into the top-of-stack field.
// RULE_11 - Other status bits and the control word are left unchanged.
// RULE_12 - Reads and state clear leave all 80 bits of every data register unchanged.
// RULE_13 - Side effects land on the same edge at which the instruction commits.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sfra_defs.vh"
module sfra_top #(
   parameter AW = 8
) (
   input  wire          aclk,        // core clock
   input  wire          aresetn,     // sync reset, active low
   input  wire [AW-1:0] awaddr,      // AXI write address
   input  wire          awvalid,     // AXI write address valid
   output wire          awready,     // AXI write address ready
   input  wire [31:0]   wdata,       // AXI write data
   input  wire [3:0]    wstrb,       // AXI byte enables
   input  wire          wvalid,      // AXI write data valid
   output wire          wready,      // AXI write data ready
   output reg  [1:0]    bresp,       // AXI write response
   output reg           bvalid,      // AXI write response valid
   input  wire          bready,      // AXI write response ready
   input  wire [AW-1:0] araddr,      // AXI read address
   input  wire          arvalid,     // AXI read address valid
   output wire          arready,     // AXI read address ready
   output reg  [31:0]   rdata,       // AXI read data
   output reg  [1:0]    rresp,       // AXI read response
   output reg           rvalid,      // AXI read data valid
   input  wire          rready,      // AXI read data ready
   input  wire          ex_valid,    // packed instruction presented
   output wire          ex_ready,    // always accepting
   input  wire [1:0]    ex_op,       // read, write or state clear
   input  wire [2:0]    ex_idx,      // packed register number
   input  wire [63:0]   ex_wdata,    // packed write data
   output reg           ex_done,     // one-cycle completion pulse
   output wire [63:0]   ex_rdata,    // packed read data
   output reg           ex_inv,      // invalid-opcode fault, with done
   output reg           ex_nav,      // not-available fault, with done
   input  wire          fp_we,       // floating-point register write
   input  wire [2:0]    fp_widx,     // physical register index
   input  wire [79:0]   fp_wdata,    // 80-bit value
   input  wire [2:0]    fp_ridx,     // floating-point read index
   output wire [79:0]   fp_rdata,    // floating-point read data
   output wire [15:0]   fp_tag_word, // tag word to the FPU
   output wire [15:0]   fp_stat_word,// status word to the FPU
   output wire [15:0]   fp_ctl_word, // control word to the FPU
   output wire          irq          // level interrupt
);

   reg  [2:0]  ctrl;
   reg  [15:0] fsw;
   reg  [15:0] ftw;
   reg  [15:0] fcw;
   reg  [3:0]  irq_stat;
   reg  [3:0]  irq_mask;
   reg  [15:0] next_fsw;
   reg  [15:0] next_ftw;
   reg  [15:0] next_fcw;
   reg  [2:0]  next_ctrl;
   reg  [3:0]  next_irq_mask;
   reg  [3:0]  next_irq_stat;
   reg         aw_held;
   reg         w_held;
   reg  [AW-1:0] aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   wire        go;
   wire        inv;
   wire        nav;
   wire        pk_write;
   wire        pk_clear;
   wire        mem_we;
   wire [2:0]  mem_widx;
   wire [79:0] mem_wdata;
   wire [79:0] ra_data;
   wire        do_write;
   wire [3:0]  evt;
   reg  [31:0] wr_merged;
   reg  [31:0] old_val;
   reg         wr_hit;
   reg  [31:0] rd_val;
   reg         rd_hit;

   sfra_gate u_gate (
      .valid (ex_valid),
      .op    (ex_op),
      .emu   (ctrl[`SFRA_CTRL_EMU]),
      .tsw   (ctrl[`SFRA_CTRL_TSW]),
      .go    (go),
      .inv   (inv),
      .nav   (nav)
   );

   assign ex_ready = 1'b1;
   assign pk_write = go && (ex_op == `SFRA_OP_WRITE);
   assign pk_clear = go && (ex_op == `SFRA_OP_CLEAR);

   // RULE_06 both views share one store
   // RULE_12 of packed instructions only writes touch data
   // Packed write wins; a same-cycle FPU write is dropped
   assign mem_we    = pk_write | fp_we;
   assign mem_widx  = pk_write ? ex_idx : fp_widx;
   // RULE_07 upper bits forced
   assign mem_wdata = pk_write ? {`SFRA_UPPER_ONES, ex_wdata} : fp_wdata;

   // RULE_04 shared storage, no copy
   // RULE_05 fixed physical index
   sfra_fp_regs #(
      .NREG (8),
      .IW   (3),
      .W    (80)
   ) u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (mem_we),
      .widx    (mem_widx),
      .wdata   (mem_wdata),
      .ra_idx  (ex_idx),
      .ra_data (ra_data),
      .rb_idx  (fp_ridx),
      .rb_data (fp_rdata)
   );

   // Valid with ex_done after a read; registered inside the store
   assign ex_rdata = ra_data[63:0];

   // Completion and fault pulses one edge after the request
   always @(posedge aclk) begin
      if (!aresetn) begin
         ex_done <= 1'b0;
         ex_inv  <= 1'b0;
         ex_nav  <= 1'b0;
      end else begin
         ex_done <= go | inv | nav;
         ex_inv  <= inv;
         ex_nav  <= nav;
      end
   end

   // Write channel: address and data taken in either order
   assign awready  = !aw_held;
   assign wready   = !w_held;
   assign do_write = aw_held && w_held && !bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= {AW{1'b0}};
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `SFRA_RESP_OKAY;
      end else begin
         if (awvalid && !aw_held) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && !w_held) begin
            w_held   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_hit ? `SFRA_RESP_OKAY : `SFRA_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Old value of the addressed register, for byte-lane merging
   always @* begin
      old_val = 32'h0000_0000;
      wr_hit  = 1'b1;
      case (aw_addr_q)
         `SFRA_OFF_CTRL:     old_val = {29'h0000_0000, ctrl};
         `SFRA_OFF_FSW:      old_val = {16'h0000, fsw};
         `SFRA_OFF_FTW:      old_val = {16'h0000, ftw};
         `SFRA_OFF_FCW:      old_val = {16'h0000, fcw};
         `SFRA_OFF_IRQ_STAT: old_val = 32'h0000_0000;
         `SFRA_OFF_IRQ_MASK: old_val = {28'h000_0000, irq_mask};
         default:            wr_hit  = 1'b0;
      endcase
      wr_merged = {w_strb_q[3] ? w_data_q[31:24] : old_val[31:24],
                   w_strb_q[2] ? w_data_q[23:16] : old_val[23:16],
                   w_strb_q[1] ? w_data_q[15:8]  : old_val[15:8],
                   w_strb_q[0] ? w_data_q[7:0]   : old_val[7:0]};
   end

   // Events raised by the instruction path
   assign evt = {pk_clear, go, nav, inv};

   // Next register values: software first, then hardware side effects
   always @* begin
      next_ctrl     = ctrl;
      next_fsw      = fsw;
      next_ftw      = ftw;
      next_fcw      = fcw;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (do_write && wr_hit) begin
         case (aw_addr_q)
            `SFRA_OFF_CTRL:     next_ctrl     = wr_merged[2:0];
            `SFRA_OFF_FSW:      next_fsw      = wr_merged[15:0];
            `SFRA_OFF_FTW:      next_ftw      = wr_merged[15:0];
            `SFRA_OFF_FCW:      next_fcw      = wr_merged[15:0];
            `SFRA_OFF_IRQ_STAT: next_irq_stat = irq_stat & ~wr_merged[3:0];
            `SFRA_OFF_IRQ_MASK: next_irq_mask = wr_merged[3:0];
            default:            next_ctrl     = ctrl;
         endcase
      end
      // A new event beats a clear in the same cycle
      next_irq_stat = next_irq_stat | evt;
      // RULE_13 same edge as commit
      if (go) begin
         // RULE_10 top of stack zeroed
         // RULE_11 other status bits kept
         next_fsw[`SFRA_TOPSTK_MSB:`SFRA_TOPSTK_LSB] = `SFRA_TOPSTK_CLEAR;
         if (pk_clear) begin
            // RULE_09 all tags empty
            next_ftw = {8{`SFRA_TAG_EMPTY}};
         end else begin
            // RULE_08 all tags valid
            next_ftw = {8{`SFRA_TAG_VALID}};
         end
      end
   end

   // State registers; control word only moves by software
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl     <= `SFRA_CTRL_RESET;
         fsw      <= `SFRA_FSW_RESET;
         ftw      <= `SFRA_FTW_RESET;
         fcw      <= `SFRA_FCW_RESET;
         irq_stat <= `SFRA_IRQ_RESET;
         irq_mask <= `SFRA_IRQ_RESET;
      end else begin
         ctrl     <= next_ctrl;
         fsw      <= next_fsw;
         ftw      <= next_ftw;
         fcw      <= next_fcw;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
      end
   end

   assign fp_tag_word  = ftw;
   assign fp_stat_word = fsw;
   assign fp_ctl_word  = fcw;
   assign irq          = |(irq_stat & irq_mask);

   // Read channel: one outstanding read, answer one cycle after address
   assign arready = !rvalid;

   always @* begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr)
         `SFRA_OFF_CTRL:     rd_val = {29'h0000_0000, ctrl};
         `SFRA_OFF_FSW:      rd_val = {16'h0000, fsw};
         `SFRA_OFF_FTW:      rd_val = {16'h0000, ftw};
         `SFRA_OFF_FCW:      rd_val = {16'h0000, fcw};
         `SFRA_OFF_IRQ_STAT: rd_val = {28'h000_0000, irq_stat};
         `SFRA_OFF_IRQ_MASK: rd_val = {28'h000_0000, irq_mask};
         default:            rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `SFRA_RESP_OKAY;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata  <= rd_val;
         rresp  <= rd_hit ? `SFRA_RESP_OKAY : `SFRA_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule // sfra_top

// *** verilog/sfra_defs.vh ***
// Constants for the packed-integer / floating-point register alias block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef SFRA_DEFS_VH
`define SFRA_DEFS_VH

// Register byte offsets
`define SFRA_OFF_CTRL      8'h00
`define SFRA_OFF_FSW       8'h04
`define SFRA_OFF_FTW       8'h08
`define SFRA_OFF_FCW       8'h0C
`define SFRA_OFF_IRQ_STAT  8'h10
`define SFRA_OFF_IRQ_MASK  8'h14

// Control register bits
`define SFRA_CTRL_EMU      0
`define SFRA_CTRL_TSW      1
`define SFRA_CTRL_MON      2

// Status word top-of-stack field
`define SFRA_TOPSTK_LSB    11
`define SFRA_TOPSTK_MSB    13
`define SFRA_TOPSTK_CLEAR  3'h0

// Tag encodings
`define SFRA_TAG_VALID     2'h0
`define SFRA_TAG_EMPTY     2'h3

// Upper exponent bits forced on a packed write
`define SFRA_UPPER_ONES    16'hFFFF

// Instruction kinds from the execution logic
`define SFRA_OP_READ       2'h0
`define SFRA_OP_WRITE      2'h1
`define SFRA_OP_CLEAR      2'h2

// Interrupt status bits
`define SFRA_IRQ_INV       0
`define SFRA_IRQ_NAV       1
`define SFRA_IRQ_EXEC      2
`define SFRA_IRQ_CLR       3

// Reset values
`define SFRA_CTRL_RESET    3'h4
`define SFRA_FSW_RESET     16'h0000
`define SFRA_FTW_RESET     16'hFFFF
`define SFRA_FCW_RESET     16'h0000
`define SFRA_IRQ_RESET     4'h0

// AXI responses
`define SFRA_RESP_OKAY     2'h0
`define SFRA_RESP_SLVERR   2'h2

`endif

// *** verilog/sfra_fp_regs.v ***
// Eight 80-bit floating-point data registers, one write port, two read ports.
// Assumes the caller arbitrates the single write port; reads are registered.
`timescale 1ns/1ps
module sfra_fp_regs #(
   parameter NREG = 8,
   parameter IW   = 3,
   parameter W    = 80
) (
   input  wire          aclk,     // core clock
   input  wire          aresetn,  // sync reset, active low
   input  wire          we,       // write enable
   input  wire [IW-1:0] widx,     // write index
   input  wire [W-1:0]  wdata,    // write data
   input  wire [IW-1:0] ra_idx,   // read port A index
   output reg  [W-1:0]  ra_data,  // read port A data
   input  wire [IW-1:0] rb_idx,   // read port B index
   output reg  [W-1:0]  rb_data   // read port B data
);

   reg [W-1:0] mem [0:NREG-1];

   // Storage; no reset, datapath only
   always @(posedge aclk) begin
      if (we) begin
         mem[widx] <= wdata;
      end
   end

   // Registered reads return the value before a same-edge write
   always @(posedge aclk) begin
      if (!aresetn) begin
         ra_data <= {W{1'b0}};
         rb_data <= {W{1'b0}};
      end else begin
         ra_data <= mem[ra_idx];
         rb_data <= mem[rb_idx];
      end
   end

endmodule // sfra_fp_regs

// *** verilog/sfra_gate.v ***
// Decides whether a packed-integer instruction runs or faults.
// Assumes flags and request come from logic on the same clock.
`timescale 1ns/1ps
`include "sfra_defs.vh"
module sfra_gate (
   input  wire       valid,  // instruction presented
   input  wire [1:0] op,     // instruction kind
   input  wire       emu,    // emulation flag
   input  wire       tsw,    // task-switched flag
   output reg        go,     // instruction executes
   output reg        inv,    // invalid-opcode fault
   output reg        nav     // device-not-available fault
);

   // Emulation flag beats task-switched; no emulation trap exists
   always @* begin
      go  = 1'b0;
      inv = 1'b0;
      nav = 1'b0;
      if (valid) begin
         // RULE_01 flag check
         // RULE_02 no emulation path
         if (emu || op == 2'h3) begin
            inv = 1'b1;
         end else if (tsw) begin
            nav = 1'b1;
         end else begin
            go = 1'b1;
         end
      end
   end

endmodule // sfra_gate

// *** verification/sfra_checker.sv ***
// Assertion checker for the packed / floating-point register alias block.
// Sees only top-level ports of sfra_top; bound at the foot of this file.
`timescale 1ns/1ps
`include "sfra_defs.vh"
module sfra_checker (
   input wire        aclk,         // core clock
   input wire        aresetn,      // sync reset, active low
   input wire        ex_valid,     // instruction presented
   input wire [1:0]  ex_op,        // instruction kind
   input wire        ex_done,      // completion pulse
   input wire        ex_inv,       // invalid-opcode fault
   input wire        ex_nav,       // not-available fault
   input wire [15:0] fp_tag_word,  // tag word
   input wire [15:0] fp_stat_word, // status word
   input wire [15:0] fp_ctl_word,  // control word
   input wire        bvalid,       // write response valid
   input wire [1:0]  bresp,        // write response
   input wire        bready,       // write response ready
   input wire        rvalid,       // read data valid
   input wire [31:0] rdata,        // read data
   input wire        rready        // read data ready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Non-clear instruction taken, then executed without fault
   sequence use_s;
      ex_valid && ex_op != `SFRA_OP_CLEAR ##1 ex_done && !ex_inv && !ex_nav;
   endsequence
   // State clear taken, then executed without fault
   sequence clr_s;
      ex_valid && ex_op == `SFRA_OP_CLEAR ##1 ex_done && !ex_inv && !ex_nav;
   endsequence

   done_follows_a: assert property (ex_valid |=> ex_done && !(ex_inv && ex_nav))
      else $error("completion missing after instruction");
   illegal_faults_a: assert property (ex_valid && ex_op == 2'h3 |=> ex_inv && !ex_nav)
      else $error("illegal kind not faulted");
   tags_valid_a: assert property (use_s |-> fp_tag_word == 16'h0000)
      else $error("tags not valid after instruction");
   tags_empty_a: assert property (clr_s |-> fp_tag_word == 16'hFFFF)
      else $error("tags not empty after state clear");
   top_zero_a: assert property ((use_s or clr_s) |-> fp_stat_word[13:11] == 3'h0)
      else $error("top of stack not zero");
   status_kept_a: assert property ((use_s or clr_s) |->
      (fp_stat_word & 16'hC7FF) == ($past(fp_stat_word) & 16'hC7FF) && $stable(fp_ctl_word))
      else $error("status or control bits changed");
   fault_quiet_a: assert property (ex_done && (ex_inv || ex_nav) |->
      $stable(fp_tag_word) && $stable(fp_stat_word))
      else $error("fault changed floating-point state");
   // Write response held until taken
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   // Read data held until taken
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
endmodule // sfra_checker

bind sfra_top sfra_checker chk_u (.aclk, .aresetn, .ex_valid, .ex_op, .ex_done, .ex_inv,
   .ex_nav, .fp_tag_word, .fp_stat_word, .fp_ctl_word, .bvalid, .bresp, .bready, .rvalid,
   .rdata, .rready);

// *** verification/sfra_exec_model.sv ***
// Model of the execution logic that issues packed and floating-point accesses.
// Assumes the bench calls its tasks from one process, on the core clock.
`timescale 1ns/1ps
module sfra_exec_model (
   input  wire         aclk,     // core clock
   output logic        ex_valid, // instruction presented
   output logic [1:0]  ex_op,    // instruction kind
   output logic [2:0]  ex_idx,   // packed register number
   output logic [63:0] ex_wdata, // packed write data
   output logic        fp_we,    // floating-point write
   output logic [2:0]  fp_widx,  // write index
   output logic [79:0] fp_wdata, // write value
   output logic [2:0]  fp_ridx   // read index
);
   // Idle values at time zero
   initial begin
      ex_valid = 1'b0;
      ex_op = 2'h0;
      ex_idx = 3'h0;
      ex_wdata = 64'h0000_0000_0000_0000;
      fp_we = 1'b0;
      fp_widx = 3'h0;
      fp_wdata = 80'h0000_0000_0000_0000_0000;
      fp_ridx = 3'h0;
   end

   // One instruction, held for one cycle; released data no longer holds its value
   task automatic issue(input logic [1:0] op, input logic [2:0] idx, input logic [63:0] d);
      @(posedge aclk);
      ex_valid <= 1'b1;
      ex_op <= op;
      ex_idx <= idx;
      ex_wdata <= d;
      @(posedge aclk);
      ex_valid <= 1'b0;
      ex_wdata <= ~d;
   endtask

   // One floating-point register write pulse
   task automatic fp_wr(input logic [2:0] idx, input logic [79:0] v);
      @(posedge aclk);
      fp_we <= 1'b1;
      fp_widx <= idx;
      fp_wdata <= v;
      @(posedge aclk);
      fp_we <= 1'b0;
      fp_wdata <= ~v;
   endtask

   // Registered read, data settles after the second edge
   task automatic fp_rd(input logic [2:0] idx);
      @(posedge aclk);
      fp_ridx <= idx;
      @(posedge aclk);
   endtask
endmodule // sfra_exec_model

// *** verification/test_simd_fp_register_alias.sv ***
// Self-checking bench for the packed / floating-point register alias block.
// Drives the AXI4-Lite registers itself; instructions come from the exec model.
`timescale 1ns/1ps
`include "sfra_defs.vh"
module test_simd_fp_register_alias;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, ex_ready, ex_done, ex_inv, ex_nav;
   wire         ex_valid, fp_we, irq;
   wire [1:0]   bresp, rresp, ex_op;
   wire [2:0]   ex_idx, fp_widx, fp_ridx;
   wire [31:0]  rdata;
   wire [63:0]  ex_wdata, ex_rdata;
   wire [79:0]  fp_wdata, fp_rdata;
   wire [15:0]  fp_tag_word, fp_stat_word, fp_ctl_word;
   int          n_errors = 0, samples_checked = 0;

   // Core clock, 100 MHz
   always #5 aclk = ~aclk;

   // Byte enables tied: every register access is a whole word
   sfra_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .ex_valid, .ex_ready, .ex_op, .ex_idx, .ex_wdata, .ex_done,
      .ex_rdata, .ex_inv, .ex_nav, .fp_we, .fp_widx, .fp_wdata, .fp_ridx, .fp_rdata,
      .fp_tag_word, .fp_stat_word, .fp_ctl_word, .irq);
   sfra_exec_model model_u (.aclk, .ex_valid, .ex_op, .ex_idx, .ex_wdata, .fp_we, .fp_widx,
      .fp_wdata, .fp_ridx);

   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Register write: address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk(bresp, er);
      bready <= 1'b0;
   endtask

   // Register read, compared against the expected word and response
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, e);
      chk(rresp, er);
      rready <= 1'b0;
   endtask

   // Reset values, and an unmapped place refused
   task automatic t_reset;
      chk(ex_ready, 1'b1);
      axr(`SFRA_OFF_CTRL, 32'h0000_0004, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_FSW, 32'h0000_0000, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_FTW, 32'h0000_FFFF, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_IRQ_STAT, 32'h0000_0000, `SFRA_RESP_OKAY);
      axw(8'h18, 32'h0000_00FF, `SFRA_RESP_SLVERR);
      axr(8'h18, 32'h0000_0000, `SFRA_RESP_SLVERR);
      $display("test reset done");
   endtask

   // Every flag combination, then an illegal kind; faults leave data alone
   task automatic t_gate;
      axw(`SFRA_OFF_CTRL, 32'h0000_0004, `SFRA_RESP_OKAY);
      model_u.issue(`SFRA_OP_WRITE, 3'h0, 64'h1111_2222_3333_4444);
      #1 chk({ex_done, ex_inv, ex_nav}, 3'h4);
      for (int k = 1; k < 4; k++) begin
         axw(`SFRA_OFF_CTRL, {29'h0, 1'b1, k[0], k[1]}, `SFRA_RESP_OKAY);
         model_u.issue(`SFRA_OP_WRITE, 3'h0, 64'hDEAD_BEEF_DEAD_BEEF);
         #1 chk({ex_done, ex_inv, ex_nav}, k[1] ? 3'h6 : 3'h5);
      end
      axw(`SFRA_OFF_CTRL, 32'h0000_0004, `SFRA_RESP_OKAY);
      model_u.issue(2'h3, 3'h0, 64'hDEAD_BEEF_DEAD_BEEF);
      #1 chk({ex_done, ex_inv, ex_nav}, 3'h6);
      model_u.fp_rd(3'h0);
      #1 chk(fp_rdata, {16'hFFFF, 64'h1111_2222_3333_4444});
      $display("test gate done");
   endtask

   // Alias in both directions, side effects on status, tags and upper bits
   task automatic t_alias;
      logic [63:0] d;
      axw(`SFRA_OFF_FSW, 32'h0000_2A55, `SFRA_RESP_OKAY);
      axw(`SFRA_OFF_FCW, 32'h0000_037F, `SFRA_RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         d = {8{i[7:0]}} ^ 64'h0123_4567_89AB_CDEF;
         model_u.issue(`SFRA_OP_WRITE, i[2:0], d);
         model_u.issue(`SFRA_OP_READ, i[2:0], 64'h0000_0000_0000_0000);
         #1 chk(ex_rdata, d);
         model_u.fp_rd(i[2:0]);
         #1 chk(fp_rdata, {16'hFFFF, d});
      end
      axr(`SFRA_OFF_FSW, 32'h0000_0255, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_FTW, 32'h0000_0000, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_FCW, 32'h0000_037F, `SFRA_RESP_OKAY);
      model_u.fp_wr(3'h5, 80'h1234_5678_9ABC_DEF0_1357);
      model_u.issue(`SFRA_OP_READ, 3'h5, 64'h0000_0000_0000_0000);
      #1 chk(ex_rdata, 64'h5678_9ABC_DEF0_1357);
      axw(`SFRA_OFF_FSW, 32'h0000_3800, `SFRA_RESP_OKAY);
      model_u.issue(`SFRA_OP_CLEAR, 3'h5, 64'h0000_0000_0000_0000);
      axr(`SFRA_OFF_FTW, 32'h0000_FFFF, `SFRA_RESP_OKAY);
      axr(`SFRA_OFF_FSW, 32'h0000_0000, `SFRA_RESP_OKAY);
      model_u.fp_rd(3'h5);
      #1 chk(fp_rdata, 80'h1234_5678_9ABC_DEF0_1357);
      $display("test alias done");
   endtask

   // Fault event raised, masked and cleared
   task automatic t_irq;
      axw(`SFRA_OFF_IRQ_STAT, 32'h0000_000F, `SFRA_RESP_OKAY);
      axw(`SFRA_OFF_IRQ_MASK, 32'h0000_0001, `SFRA_RESP_OKAY);
      axw(`SFRA_OFF_CTRL, 32'h0000_0005, `SFRA_RESP_OKAY);
      model_u.issue(`SFRA_OP_WRITE, 3'h1, 64'h0000_0000_0000_0000);
      #1 chk(irq, 1'b1);
      axr(`SFRA_OFF_IRQ_STAT, 32'h0000_0001, `SFRA_RESP_OKAY);
      axw(`SFRA_OFF_IRQ_MASK, 32'h0000_0000, `SFRA_RESP_OKAY);
      chk(irq, 1'b0);
      axw(`SFRA_OFF_IRQ_MASK, 32'h0000_0001, `SFRA_RESP_OKAY);
      chk(irq, 1'b1);
      axw(`SFRA_OFF_IRQ_STAT, 32'h0000_0001, `SFRA_RESP_OKAY);
      chk(irq, 1'b0);
      axw(`SFRA_OFF_CTRL, 32'h0000_0004, `SFRA_RESP_OKAY);
      $display("test irq done");
   endtask

   // Main sequence: reset held four cycles, then each test
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_gate;
      t_alias;
      t_irq;
      end_of_test;
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      n_errors++;
      end_of_test;
   end
endmodule // test_simd_fp_register_alias
